// *** hw/dsp_defs.svh ***
// Timing, widths and bit positions of the deep-sleep power sequencer
`ifndef DSP_DEFS_SVH
`define DSP_DEFS_SVH

`define DSP_HI            1'h1
`define DSP_LO            1'h0

`define DSP_CLK_NS        5
`define DSP_CNT_W         12
`define DSP_CNT_ZERO      12'h000
`define DSP_CNT_ONE       12'h001

// Power-on settle time before the rails are requested
`define DSP_INIT_NS       1000
`define DSP_INIT_CYC      12'((`DSP_INIT_NS + `DSP_CLK_NS - 1) / `DSP_CLK_NS)
// Quiet time a wake or key input must hold before it counts
`define DSP_DEBOUNCE_NS   20000
`define DSP_DEBOUNCE_CYC  \
	12'((`DSP_DEBOUNCE_NS + `DSP_CLK_NS - 1) / `DSP_CLK_NS)
// Partner's standby interval from reserve to grant in automatic mode
`define DSP_AUTO_WAIT_NS  10000
`define DSP_AUTO_WAIT_CYC \
	12'((`DSP_AUTO_WAIT_NS + `DSP_CLK_NS - 1) / `DSP_CLK_NS)

// Wake input vector, all active low
`define DSP_WAKE_W        7
`define DSP_WAKE_IDLE     7'h7f
`define DSP_WAKE_KEY      0
`define DSP_WAKE_DOC      1
`define DSP_WAKE_HOOK     2
`define DSP_WAKE_RING     3
`define DSP_WAKE_LINE_A   4
`define DSP_WAKE_LINE_B   5
`define DSP_WAKE_HOST     6

`endif

// *** hw/dsp_pkg.sv ***
// Types shared by both ends of the deep-sleep power handshake
package dsp_pkg;

	typedef enum logic [7:0] {
		DSP_D_INIT   = 8'h01,
		DSP_D_WAIT   = 8'h02,
		DSP_D_IDLE   = 8'h04,
		DSP_D_ARESV  = 8'h08,
		DSP_D_MREQ   = 8'h10,
		DSP_D_MRESV  = 8'h20,
		DSP_D_CUT    = 8'h40,
		DSP_D_SLEEP  = 8'h80
	} dsp_dev_state_t;

	typedef enum logic [5:0] {
		DSP_P_BOOT   = 6'h01,
		DSP_P_HELLO  = 6'h02,
		DSP_P_IDLE   = 6'h04,
		DSP_P_ARESV  = 6'h08,
		DSP_P_MREQ   = 6'h10,
		DSP_P_DONE   = 6'h20
	} dsp_ptn_state_t;

	typedef struct packed {
		logic [6:0]  sync1;
		logic [6:0]  sync2;
		logic [6:0]  cand;
		logic [6:0]  stable;
		logic [11:0] cnt;
	} dsp_deb_t;

endpackage

// *** hw/dsp_if.sv ***
// Handshake lines between the sequencer and its I/O-port partner
`timescale 1ns/1ps

interface dsp_if;
	logic sleep_grant;
	logic sleep_refuse;
	logic sleep_reserve_n;
	logic sleep_request_n;
	logic ring_request_n;
	logic port_enable_n;

	modport dev (
		input  sleep_grant,
		input  sleep_refuse,
		input  sleep_reserve_n,
		output sleep_request_n,
		output ring_request_n,
		output port_enable_n
	);

	modport ptn (
		output sleep_grant,
		output sleep_refuse,
		output sleep_reserve_n,
		input  sleep_request_n,
		input  ring_request_n,
		input  port_enable_n
	);
endinterface

// *** hw/dsp_debounce.sv ***
// Synchroniser and shared-timer debouncer for the active-low wake inputs
`timescale 1ns/1ps
`include "dsp_defs.svh"

module dsp_debounce (
	input  logic                   ref_clk,
	input  logic                   resetn,
	input  logic [`DSP_WAKE_W-1:0] raw_n,
	output logic [`DSP_WAKE_W-1:0] clean_n
);
	dsp_pkg::dsp_deb_t r;
	dsp_pkg::dsp_deb_t next_r;

	// One timer for all bits: any change restarts it, so a noisy input
	// delays the others slightly, which is harmless for wake sources
	always_comb begin
		next_r = r;
		next_r.sync1 = raw_n;
		next_r.sync2 = r.sync1;
		if (r.sync2 != r.cand) begin
			next_r.cand = r.sync2;
			next_r.cnt = `DSP_CNT_ZERO;
		end else if (r.cand != r.stable) begin
			if (r.cnt == `DSP_DEBOUNCE_CYC - `DSP_CNT_ONE) begin
				next_r.stable = r.cand;
				next_r.cnt = `DSP_CNT_ZERO;
			end else begin
				next_r.cnt = r.cnt + `DSP_CNT_ONE;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			r <= '{`DSP_WAKE_IDLE, `DSP_WAKE_IDLE, `DSP_WAKE_IDLE,
				`DSP_WAKE_IDLE, `DSP_CNT_ZERO};
		end else begin
			r <= next_r;
		end
	end

	assign clean_n = r.stable;
endmodule // dsp_debounce

// *** hw/dsp_sequencer.sv ***
// Always-on deep-sleep power sequencer: rails, save LED and partner handshake
`timescale 1ns/1ps
`include "dsp_defs.svh"

module dsp_sequencer (
	input  logic  ref_clk,
	input  logic  resetn,
	input  logic  auto_mode,
	input  logic  key_wake_n,
	input  logic  doc_present_n,
	input  logic  hook_detect_n,
	input  logic  ring_detect_n,
	input  logic  line_current_a_n,
	input  logic  line_current_b_n,
	input  logic  host_wake_n,
	dsp_if.dev    link,
	output logic  supply_enable,
	output logic  save_led_n,
	output logic  in_deep_save
);
	typedef struct packed {
		dsp_pkg::dsp_dev_state_t state;
		logic [11:0]             cnt;
		logic [2:0]              sync1;
		logic [2:0]              sync2;
		logic                    key_prev;
		logic                    supply_enable;
		logic                    port_enable_n;
		logic                    save_led_n;
		logic                    sleep_request_n;
		logic                    ring_request_n;
		logic                    in_deep_save;
	} dsp_seq_t;

	dsp_seq_t                r;
	dsp_seq_t                next_r;
	logic [`DSP_WAKE_W-1:0]  wake_raw_n;
	logic [`DSP_WAKE_W-1:0]  wake_n;
	logic                    grant;
	logic                    refuse;
	logic                    reserved;
	logic                    key_press;

	assign wake_raw_n = {host_wake_n, line_current_b_n, line_current_a_n,
		ring_detect_n, hook_detect_n, doc_present_n, key_wake_n};

	dsp_debounce u_debounce (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.raw_n   (wake_raw_n),
		.clean_n (wake_n)
	);

	// Partner lines cross from another chip, so they are synchronised too
	assign grant     = r.sync2[2];
	assign refuse    = r.sync2[1];
	assign reserved  = ~r.sync2[0];
	assign key_press = r.key_prev & ~wake_n[`DSP_WAKE_KEY];

	// Withdraws the request and returns to normal running
	function automatic dsp_seq_t cancel_save(input dsp_seq_t s);
		dsp_seq_t o;
		o = s;
		o.sleep_request_n = `DSP_HI;
		o.save_led_n = `DSP_HI;
		o.state = dsp_pkg::DSP_D_IDLE;
		return o;
	endfunction

	always_comb begin
		next_r = r;
		next_r.sync1 = {link.sleep_grant, link.sleep_refuse,
			link.sleep_reserve_n};
		next_r.sync2 = r.sync1;
		next_r.key_prev = wake_n[`DSP_WAKE_KEY];
		unique case (r.state)
			dsp_pkg::DSP_D_INIT: begin
				if (r.cnt == `DSP_INIT_CYC - `DSP_CNT_ONE) begin
					next_r.supply_enable = `DSP_HI;
					next_r.cnt = `DSP_CNT_ZERO;
					next_r.state = dsp_pkg::DSP_D_WAIT;
				end else begin
					next_r.cnt = r.cnt + `DSP_CNT_ONE;
				end
			end
			dsp_pkg::DSP_D_WAIT: begin
				// Ring request stays low until the partner is back up
				if (grant && refuse) begin
					next_r.port_enable_n = `DSP_LO;
					next_r.ring_request_n = `DSP_HI;
					next_r.state = dsp_pkg::DSP_D_IDLE;
				end
			end
			dsp_pkg::DSP_D_IDLE: begin
				// In automatic mode both lines must be low again before a new entry counts
				if (auto_mode) begin
					if (reserved && !grant && !refuse) begin
						next_r.save_led_n = `DSP_LO;
						next_r.state = dsp_pkg::DSP_D_ARESV;
					end
				end else if (key_press) begin
					next_r.sleep_request_n = `DSP_LO;
					next_r.state = dsp_pkg::DSP_D_MREQ;
				end
			end
			dsp_pkg::DSP_D_ARESV: begin
				if (grant) begin
					next_r.supply_enable = `DSP_LO;
					next_r.port_enable_n = `DSP_HI;
					next_r.in_deep_save = `DSP_HI;
					next_r.state = dsp_pkg::DSP_D_SLEEP;
				end else if (refuse || !reserved) begin
					next_r = cancel_save(r);
					next_r.sync1 = {link.sleep_grant, link.sleep_refuse,
						link.sleep_reserve_n};
					next_r.sync2 = r.sync1;
					next_r.key_prev = wake_n[`DSP_WAKE_KEY];
				end
			end
			dsp_pkg::DSP_D_MREQ, dsp_pkg::DSP_D_MRESV: begin
				if (grant) begin
					next_r.sleep_request_n = `DSP_HI;
					next_r.state = dsp_pkg::DSP_D_CUT;
				end else if (refuse || key_press) begin
					next_r = cancel_save(r);
					next_r.sync1 = {link.sleep_grant, link.sleep_refuse,
						link.sleep_reserve_n};
					next_r.sync2 = r.sync1;
					next_r.key_prev = wake_n[`DSP_WAKE_KEY];
				end else if (reserved) begin
					next_r.save_led_n = `DSP_LO;
					next_r.state = dsp_pkg::DSP_D_MRESV;
				end
			end
			dsp_pkg::DSP_D_CUT: begin
				// Request was returned high one cycle before the rails drop
				next_r.supply_enable = `DSP_LO;
				next_r.port_enable_n = `DSP_HI;
				next_r.save_led_n = `DSP_LO;
				next_r.in_deep_save = `DSP_HI;
				next_r.state = dsp_pkg::DSP_D_SLEEP;
			end
			dsp_pkg::DSP_D_SLEEP: begin
				if (wake_n != `DSP_WAKE_IDLE) begin
					next_r.supply_enable = `DSP_HI;
					next_r.in_deep_save = `DSP_LO;
					next_r.ring_request_n = wake_n[`DSP_WAKE_RING];
					next_r.save_led_n = auto_mode ? `DSP_LO : `DSP_HI;
					next_r.state = dsp_pkg::DSP_D_WAIT;
				end
			end
			default: begin
				next_r.state = dsp_pkg::DSP_D_INIT;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			r <= '{
				state:           dsp_pkg::DSP_D_INIT,
				cnt:             `DSP_CNT_ZERO,
				sync1:           3'h1,
				sync2:           3'h1,
				key_prev:        `DSP_HI,
				supply_enable:   `DSP_LO,
				port_enable_n:   `DSP_HI,
				save_led_n:      `DSP_HI,
				sleep_request_n: `DSP_HI,
				ring_request_n:  `DSP_HI,
				in_deep_save:    `DSP_LO
			};
		end else begin
			r <= next_r;
		end
	end

	assign supply_enable        = r.supply_enable;
	assign save_led_n           = r.save_led_n;
	assign in_deep_save         = r.in_deep_save;
	assign link.port_enable_n   = r.port_enable_n;
	assign link.sleep_request_n = r.sleep_request_n;
	assign link.ring_request_n  = r.ring_request_n;
endmodule // dsp_sequencer

// *** hw/dsp_partner.sv ***
// I/O-port partner end of the deep-sleep handshake
`timescale 1ns/1ps
`include "dsp_defs.svh"

module dsp_partner (
	input  logic  ref_clk,
	input  logic  resetn,
	dsp_if.ptn    link,
	input  logic  operational,
	input  logic  auto_mode,
	input  logic  standby,
	input  logic  busy,
	input  logic  error_pending,
	input  logic  image_held,
	output logic  ring_seen,
	output logic  ports_enabled
);
	typedef struct packed {
		dsp_pkg::dsp_ptn_state_t state;
		logic [11:0]             cnt;
		logic [2:0]              sync1;
		logic [2:0]              sync2;
		logic                    grant;
		logic                    refuse;
		logic                    reserve_n;
	} dsp_ptn_t;

	dsp_ptn_t  r;
	dsp_ptn_t  next_r;
	logic      req;

	assign req = ~r.sync2[2];

	always_comb begin
		next_r = r;
		next_r.sync1 = {link.sleep_request_n, link.ring_request_n,
			link.port_enable_n};
		next_r.sync2 = r.sync1;
		unique case (r.state)
			dsp_pkg::DSP_P_BOOT: begin
				if (operational) begin
					next_r.grant = `DSP_HI;
					next_r.refuse = `DSP_HI;
					next_r.state = dsp_pkg::DSP_P_HELLO;
				end
			end
			dsp_pkg::DSP_P_HELLO: begin
				if (!r.sync2[0]) begin
					next_r.grant = `DSP_LO;
					next_r.refuse = `DSP_LO;
					next_r.state = dsp_pkg::DSP_P_IDLE;
				end
			end
			dsp_pkg::DSP_P_IDLE: begin
				if (auto_mode && standby) begin
					next_r.reserve_n = `DSP_LO;
					next_r.cnt = `DSP_CNT_ZERO;
					next_r.state = dsp_pkg::DSP_P_ARESV;
				end else if (!auto_mode && req) begin
					next_r.reserve_n = `DSP_LO;
					next_r.state = dsp_pkg::DSP_P_MREQ;
				end
			end
			dsp_pkg::DSP_P_ARESV: begin
				if (!standby) begin
					next_r.reserve_n = `DSP_HI;
					next_r.state = dsp_pkg::DSP_P_IDLE;
				end else if (r.cnt == `DSP_AUTO_WAIT_CYC - `DSP_CNT_ONE) begin
					next_r.grant = `DSP_HI;
					next_r.state = dsp_pkg::DSP_P_DONE;
				end else begin
					next_r.cnt = r.cnt + `DSP_CNT_ONE;
				end
			end
			dsp_pkg::DSP_P_MREQ: begin
				// Held reserved until the running process is over
				if (!req) begin
					next_r.reserve_n = `DSP_HI;
					next_r.state = dsp_pkg::DSP_P_IDLE;
				end else if (!busy) begin
					if (error_pending || image_held) begin
						next_r.refuse = `DSP_HI;
					end else begin
						next_r.grant = `DSP_HI;
					end
					next_r.state = dsp_pkg::DSP_P_DONE;
				end
			end
			dsp_pkg::DSP_P_DONE: begin
				// An automatic grant is held until the rails go away
				if (!req && (r.refuse || !auto_mode)) begin
					next_r.grant = `DSP_LO;
					next_r.refuse = `DSP_LO;
					next_r.reserve_n = `DSP_HI;
					next_r.state = dsp_pkg::DSP_P_IDLE;
				end
			end
			default: begin
				next_r.state = dsp_pkg::DSP_P_BOOT;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			r <= '{
				state:     dsp_pkg::DSP_P_BOOT,
				cnt:       `DSP_CNT_ZERO,
				sync1:     3'h7,
				sync2:     3'h7,
				grant:     `DSP_LO,
				refuse:    `DSP_LO,
				reserve_n: `DSP_HI
			};
		end else begin
			r <= next_r;
		end
	end

	assign link.sleep_grant     = r.grant;
	assign link.sleep_refuse    = r.refuse;
	assign link.sleep_reserve_n = r.reserve_n;
	assign ring_seen            = ~r.sync2[1];
	assign ports_enabled        = ~r.sync2[0];
endmodule // dsp_partner

// *** bench/dsp_sva.sv ***
// Concurrent checks on the deep-sleep handshake and rail outputs
`timescale 1ns/1ps

module dsp_sva (
	input logic ref_clk,
	input logic resetn,
	input logic auto_mode,
	input logic sleep_grant,
	input logic sleep_refuse,
	input logic sleep_reserve_n,
	input logic sleep_request_n,
	input logic ring_request_n,
	input logic port_enable_n,
	input logic supply_enable,
	input logic save_led_n,
	input logic in_deep_save
);
	logic both;

	assign both = sleep_grant & sleep_refuse;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_cut_on_grant: assert property (
		$fell(supply_enable) |-> $past(sleep_grant, 2) && sleep_request_n
		&& !save_led_n && in_deep_save)
		else $error("rails cut without grant");
	a_deep_rails_off: assert property (
		in_deep_save |-> !supply_enable && port_enable_n)
		else $error("deep save with rails or ports on");
	a_port_cause: assert property (
		$fell(port_enable_n) |-> $past(both, 2))
		else $error("ports enabled without partner ready");
	a_port_release: assert property (
		$fell(port_enable_n) |-> ##[1:6] !sleep_grant && !sleep_refuse)
		else $error("partner kept ready lines high");
	a_led_on_reserve: assert property (
		$fell(save_led_n) |-> !$past(sleep_reserve_n, 2))
		else $error("led lit without reserve");
	a_request_manual: assert property (
		$fell(sleep_request_n) |-> !auto_mode && supply_enable && save_led_n)
		else $error("request outside manual idle");
	a_refuse_cancel: assert property (
		$rose(sleep_refuse) && !sleep_grant && !sleep_request_n |->
		##[1:5] sleep_request_n && save_led_n && supply_enable)
		else $error("refuse not honoured");
	a_wake_restore: assert property (
		$fell(in_deep_save) |-> supply_enable && save_led_n == !auto_mode)
		else $error("bad state after wake");
	a_ring_on_wake: assert property (
		$fell(ring_request_n) |-> $fell(in_deep_save))
		else $error("ring request outside wake");
endmodule // dsp_sva

// *** bench/deep_sleep_power_sequencer_test.sv ***
// Self-checking bench joining sequencer and partner across the handshake
`timescale 1ns/1ps
`include "dsp_defs.svh"

module deep_sleep_power_sequencer_test;
	logic       ref_clk;
	logic       resetn;
	logic       p_resetn;
	logic       auto_mode;
	logic [6:0] wake_n;
	logic       standby;
	logic       busy;
	logic       error_pending;
	logic       image_held;
	logic       operational;
	logic       supply_enable;
	logic       save_led_n;
	logic       in_deep_save;
	logic       ring_seen;
	logic       ports_enabled;
	logic [2:0] obs;
	logic [2:0] prev;
	logic [2:0] q[$];
	logic [6:0] mask;
	int         err_total;
	int         compares;

	dsp_if link();
	// Partner sits on the cut rails, so it stays in reset while they are off
	assign p_resetn = resetn & supply_enable;
	assign obs = {supply_enable, in_deep_save, save_led_n};

	dsp_sequencer i_dsp_sequencer (.ref_clk(ref_clk), .resetn(resetn),
		.auto_mode(auto_mode), .key_wake_n(wake_n[`DSP_WAKE_KEY]),
		.doc_present_n(wake_n[`DSP_WAKE_DOC]),
		.hook_detect_n(wake_n[`DSP_WAKE_HOOK]),
		.ring_detect_n(wake_n[`DSP_WAKE_RING]),
		.line_current_a_n(wake_n[`DSP_WAKE_LINE_A]),
		.line_current_b_n(wake_n[`DSP_WAKE_LINE_B]),
		.host_wake_n(wake_n[`DSP_WAKE_HOST]), .link(link.dev),
		.supply_enable(supply_enable), .save_led_n(save_led_n),
		.in_deep_save(in_deep_save));
	dsp_partner i_dsp_partner (.ref_clk(ref_clk), .resetn(p_resetn),
		.link(link.ptn), .operational(operational), .auto_mode(auto_mode),
		.standby(standby), .busy(busy), .error_pending(error_pending),
		.image_held(image_held), .ring_seen(ring_seen),
		.ports_enabled(ports_enabled));
	dsp_sva i_dsp_sva (.ref_clk(ref_clk), .resetn(resetn),
		.auto_mode(auto_mode), .sleep_grant(link.sleep_grant),
		.sleep_refuse(link.sleep_refuse),
		.sleep_reserve_n(link.sleep_reserve_n),
		.sleep_request_n(link.sleep_request_n),
		.ring_request_n(link.ring_request_n),
		.port_enable_n(link.port_enable_n), .supply_enable(supply_enable),
		.save_led_n(save_led_n), .in_deep_save(in_deep_save));

	initial begin
		ref_clk = 1'h0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic results;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic step;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic pin(input int i, input logic v);
		step();
		wake_n[i] = v;
	endtask

	// Inputs count only after the debounce window has passed
	task automatic settle;
		repeat (4100) @(posedge ref_clk);
	endtask

	task automatic drain(input int n);
		for (int i = 0; i < n && q.size() != 0; i++)
			@(posedge ref_clk);
		if (q.size() != 0) begin
			$display("mismatch notes expected 0 seen %0d", q.size());
			err_total++;
		end
	endtask

	task automatic wait_hi(input bit ring);
		logic f;
		for (int i = 0; i < 2000; i++) begin
			@(negedge ref_clk);
			f = ring ? ring_seen : ports_enabled;
			if (f === 1'h1)
				break;
		end
		compares++;
		if (f !== 1'h1) begin
			$display("mismatch %s expected 1 seen %b",
				ring ? "ring_seen" : "ports_enabled", f);
			err_total++;
		end
	endtask

	// Every change of rails, sleep flag or LED must match the oldest note
	always @(negedge ref_clk) begin
		if (resetn === 1'h1 && obs !== prev) begin
			compares++;
			if (q.size() == 0 || q[0] !== obs) begin
				$display("mismatch rails_led expected %b seen %b",
					q.size() ? q[0] : 3'hx, obs);
				err_total++;
			end
			if (q.size() != 0)
				void'(q.pop_front());
		end
		prev = obs;
	end

	initial begin
		#400000;
		$display("mismatch watchdog expected done seen hang");
		err_total++;
		results();
	end

	initial begin
		resetn = 1'h0;
		auto_mode = 1'h0;
		wake_n = `DSP_WAKE_IDLE;
		standby = 1'h0;
		busy = 1'h1;
		operational = 1'h0;
		err_total = 0;
		compares = 0;
		void'($urandom(32'h1c30_4468));
		// Either cause, or both, makes the partner refuse
		{error_pending, image_held} = 2'($urandom % 3 + 1);
		repeat (10) @(posedge ref_clk);
		#1 resetn = 1'h1;
		q.push_back(3'h5);
		drain(300);
		// Ports stay off until the partner reports operational
		repeat (20) step();
		compares++;
		if (link.port_enable_n !== 1'h1) begin
			$display("mismatch port_enable_n expected 1 seen %b",
				link.port_enable_n);
			err_total++;
		end
		operational = 1'h1;
		wait_hi(0);
		// Manual entry refused while an error is pending or an image is held
		q.push_back(3'h4);
		pin(`DSP_WAKE_KEY, 1'h0);
		drain(4300);
		pin(`DSP_WAKE_KEY, 1'h1);
		settle();
		q.push_back(3'h5);
		step();
		busy = 1'h0;
		drain(60);
		step();
		busy = 1'h1;
		error_pending = 1'h0;
		image_held = 1'h0;
		settle();
		// Second press cancels the reservation
		q.push_back(3'h4);
		q.push_back(3'h5);
		pin(`DSP_WAKE_KEY, 1'h0);
		settle();
		pin(`DSP_WAKE_KEY, 1'h1);
		settle();
		pin(`DSP_WAKE_KEY, 1'h0);
		drain(4300);
		pin(`DSP_WAKE_KEY, 1'h1);
		settle();
		// Manual entry granted, then woken by a random source
		q.push_back(3'h4);
		pin(`DSP_WAKE_KEY, 1'h0);
		drain(4300);
		pin(`DSP_WAKE_KEY, 1'h1);
		settle();
		q.push_back(3'h2);
		step();
		busy = 1'h0;
		drain(60);
		// Any mix of the non-ring sources must wake the rails
		mask = 7'($urandom) & ~(7'h01 << `DSP_WAKE_RING);
		if (mask == 7'h00)
			mask = 7'h01 << `DSP_WAKE_DOC;
		q.push_back(3'h5);
		step();
		wake_n = ~mask;
		drain(4300);
		step();
		wake_n = `DSP_WAKE_IDLE;
		wait_hi(0);
		compares++;
		if (ring_seen !== 1'h0) begin
			$display("mismatch ring_seen expected 0 seen %b", ring_seen);
			err_total++;
		end
		settle();
		// Automatic entry, ring wake keeps the LED lit
		step();
		auto_mode = 1'h1;
		// Standby withdrawn before the grant drops the reservation
		q.push_back(3'h4);
		q.push_back(3'h5);
		step();
		standby = 1'h1;
		repeat (20) step();
		standby = 1'h0;
		drain(60);
		q.push_back(3'h4);
		q.push_back(3'h2);
		step();
		standby = 1'h1;
		drain(2200);
		step();
		standby = 1'h0;
		q.push_back(3'h4);
		pin(`DSP_WAKE_RING, 1'h0);
		drain(4300);
		wait_hi(1);
		pin(`DSP_WAKE_RING, 1'h1);
		wait_hi(0);
		settle();
		results();
	end
endmodule // deep_sleep_power_sequencer_test
